// File: logic/pmoc_pkg.sv
// constants for the power mode and output control block
package pmoc_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [5:0] OFS_STATUS   = 6'h00;
  localparam logic [5:0] OFS_CONTROL  = 6'h01;
  localparam logic [5:0] OFS_IO       = 6'h03;
  localparam logic [5:0] OFS_BIAS     = 6'h04;
  localparam logic [5:0] OFS_ERR_EN   = 6'h05;
  localparam logic [5:0] OFS_CHANNEL0 = 6'h09;
  localparam logic [5:0] OFS_CONFIG0  = 6'h19;
  localparam logic [5:0] OFS_FILTER0  = 6'h21;
  // reset values
  localparam logic [15:0] RST_IO       = 16'h0000;
  localparam logic [15:0] RST_CONTROL  = 16'h0040;
  localparam logic [15:0] RST_CHANNEL0 = 16'h8001;
  localparam logic [15:0] RST_CONFIG0  = 16'h0000;
  localparam logic [15:0] RST_FILTER0  = 16'h0030;
  localparam logic [15:0] RST_ERR_EN   = 16'h0001;
  localparam logic [15:0] RST_BIAS     = 16'h0000;
  // field positions
  localparam int IO_EN_LSB   = 0;
  localparam int IO_LVL_LSB  = 4;
  localparam int IO_INT_BIT  = 8;
  localparam int IO_SBY_BIT  = 9;
  localparam int IO_SYNC_BIT = 10;
  localparam int CTL_MODE_LSB = 2;
  localparam int CFG_GAIN_LSB = 0;
  localparam int CFG_BYP_BIT  = 3;
  localparam int CH_SW_BIT    = 14;
  localparam int ST_POR_BIT   = 6;
  localparam int ST_NRDY_BIT  = 7;
  localparam int NUM_OUT = 4;
  localparam int NUM_CH  = 16;
  localparam int NUM_CFG = 8;
  localparam int NUM_AIN = 16;
  localparam logic [2:0] GAIN_ONE = 3'h0;
  // operating mode codes
  typedef enum logic [3:0] {
    PMOC_MODE_CONT  = 4'b0000,
    PMOC_MODE_STBY  = 4'b0010,
    PMOC_MODE_PDOWN = 4'b0011,
    PMOC_MODE_IDLE  = 4'b0100
  } pmoc_mode_t;
endpackage : pmoc_pkg

// File: logic/pmoc_power_ctrl.sv
// power mode, output pin and setup control
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - four outputs, each enabled by own bit
// - enabled output drives its level bit
// - pin two interrupt, pin four standby
// - per setup gain field, one to 128
// - bypass bit forces gain of one
// - supply reset restores config, analog ignored
// - reset flag set, cleared by read
// - channel zero enabled, inputs zero/one, setup zero
// - setup zero defaults, rate field 0x30
// - control register conversion defaults
// - only ignored-transaction diagnostic enabled
// - mode codes standby, power-down, idle
// - power-down only from standby
// - power-down leaves only through reset
// - idle holds modulator and filter reset
// - per pin bias generator select
// - channel bridge switch bit drives switch
// - sixteen channels, eight setups
// - standby forces not-ready bit high
module pmoc_power_ctrl #(
  parameter int NUM_CH  = pmoc_pkg::NUM_CH,
  parameter int NUM_CFG = pmoc_pkg::NUM_CFG
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // supply monitors from analog pins
  input  wire logic                       ioSupplyLow,
  input  wire logic                       digLdoLow,
  input  wire logic                       anaSupplyLow,
  // register port
  input  wire logic [pmoc_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [pmoc_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [pmoc_pkg::DATA_W-1:0] regRdata,
  // sequencer and converter status
  input  wire logic [3:0]                 activeChannel,
  input  wire logic                       convReady,
  input  wire logic                       convIrq,
  // general output pins
  output logic      [pmoc_pkg::NUM_OUT-1:0] outPinData,
  output logic      [pmoc_pkg::NUM_OUT-1:0] outPinEnable,
  // analog control
  output logic      [pmoc_pkg::NUM_AIN-1:0] biasSelect,
  output logic                            bridgeSwitchOn,
  output logic      [2:0]                 effectiveGain,
  output logic                            modResetHold,
  output logic                            standbyActive,
  output logic                            powerDownActive
);
  import pmoc_pkg::*;

  initial begin
    if (NUM_CH < 1 || NUM_CH > 16 || NUM_CFG < 1 || NUM_CFG > 8) begin
      $error("pmoc_power_ctrl: channel or setup count out of range");
    end
  end

  typedef struct packed {
    logic [15:0]            io;
    logic [15:0]            control;
    logic [15:0]            bias;
    logic [15:0]            errEn;
    logic [NUM_CH-1:0][15:0]  channel;
    logic [NUM_CFG-1:0][15:0] config_;
    logic [NUM_CFG-1:0][15:0] filter;
    logic                   porFlag;
    logic                   pdown;
    logic [2:0]             supplySync1;
    logic [2:0]             supplySync2;
    logic [15:0]            rdata;
  } pmoc_state_t;

  pmoc_state_t r;
  pmoc_state_t next_r;

  logic [2:0]  chSetup;
  logic [15:0] cfgSel;
  logic        supplyBad;
  pmoc_mode_t  modeNow;
  logic [3:0]  wrMode;
  logic [15:0] statusWord;

  always_comb begin
    modeNow       = pmoc_mode_t'(r.control[CTL_MODE_LSB +: 4]);
    standbyActive = (modeNow == PMOC_MODE_STBY);
    modResetHold  = (modeNow == PMOC_MODE_IDLE) || r.pdown;
    powerDownActive = r.pdown;
    // analog supply dip ignored
    supplyBad     = r.supplySync2[0] | r.supplySync2[1];
    chSetup       = r.channel[activeChannel][12 +: 3];
    cfgSel        = r.config_[chSetup[$clog2(NUM_CFG > 1 ? NUM_CFG : 2)-1:0]];
    effectiveGain = cfgSel[CFG_BYP_BIT] ? GAIN_ONE : cfgSel[CFG_GAIN_LSB +: 3];
    bridgeSwitchOn = r.channel[activeChannel][CH_SW_BIT] & ~r.pdown;
    biasSelect    = r.bias;
    statusWord    = '0;
    statusWord[ST_POR_BIT]  = r.porFlag;
    statusWord[ST_NRDY_BIT] = standbyActive | ~convReady;
    statusWord[3:0]         = activeChannel;
  end

  // output pins with repurposing
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      always_comb begin
        outPinEnable[gi] = r.io[IO_EN_LSB + gi] & ~r.pdown;
        outPinData[gi]   = r.io[IO_LVL_LSB + gi];
        if (gi == 1 && r.io[IO_INT_BIT]) begin
          outPinData[gi] = convIrq;
        end
        if (gi == 3 && r.io[IO_SBY_BIT]) begin
          outPinData[gi] = standbyActive;
        end
      end
    end
  endgenerate

  always_comb begin
    next_r = r;
    wrMode = regWdata[CTL_MODE_LSB +: 4];
    next_r.supplySync1 = {anaSupplyLow, digLdoLow, ioSupplyLow};
    next_r.supplySync2 = r.supplySync1;
    next_r.rdata = '0;
    if (regRd && !r.pdown) begin
      case (regAddr)
        OFS_STATUS:  next_r.rdata = statusWord;
        OFS_CONTROL: next_r.rdata = r.control;
        OFS_IO:      next_r.rdata = r.io;
        OFS_BIAS:    next_r.rdata = r.bias;
        OFS_ERR_EN:  next_r.rdata = r.errEn;
        default: begin
          if (regAddr >= OFS_CHANNEL0 && regAddr < OFS_CHANNEL0 + 6'(NUM_CH)) begin
            next_r.rdata = r.channel[4'(regAddr - OFS_CHANNEL0)];
          end else if (regAddr >= OFS_CONFIG0 && regAddr < OFS_CONFIG0 + 6'(NUM_CFG)) begin
            next_r.rdata = r.config_[3'(regAddr - OFS_CONFIG0)];
          end else if (regAddr >= OFS_FILTER0 && regAddr < OFS_FILTER0 + 6'(NUM_CFG)) begin
            next_r.rdata = r.filter[3'(regAddr - OFS_FILTER0)];
          end
        end
      endcase
      if (regAddr == OFS_STATUS) begin
        next_r.porFlag = 1'b0;
      end
    end
    if (regWr && !r.pdown) begin
      case (regAddr)
        OFS_CONTROL: begin
          next_r.control = regWdata;
          if (wrMode == PMOC_MODE_PDOWN) begin
            if (modeNow == PMOC_MODE_STBY) begin
              next_r.pdown = 1'b1;
            end else begin
              next_r.control[CTL_MODE_LSB +: 4] = PMOC_MODE_CONT;
            end
          end
        end
        OFS_IO:     next_r.io    = regWdata;
        OFS_BIAS:   next_r.bias  = regWdata;
        OFS_ERR_EN: next_r.errEn = regWdata;
        default: begin
          if (regAddr >= OFS_CHANNEL0 && regAddr < OFS_CHANNEL0 + 6'(NUM_CH)) begin
            next_r.channel[4'(regAddr - OFS_CHANNEL0)] = regWdata;
          end else if (regAddr >= OFS_CONFIG0 && regAddr < OFS_CONFIG0 + 6'(NUM_CFG)) begin
            next_r.config_[3'(regAddr - OFS_CONFIG0)] = regWdata;
          end else if (regAddr >= OFS_FILTER0 && regAddr < OFS_FILTER0 + 6'(NUM_CFG)) begin
            next_r.filter[3'(regAddr - OFS_FILTER0)] = regWdata;
          end
        end
      endcase
    end
    // supply drop: restore defaults, flag set wins over read clear
    if (supplyBad) begin
      next_r.io      = RST_IO;
      next_r.control = RST_CONTROL;
      next_r.bias    = RST_BIAS;
      next_r.errEn   = RST_ERR_EN;
      next_r.channel = '0;
      next_r.channel[0] = RST_CHANNEL0;
      next_r.config_ = '0;
      next_r.config_[0] = RST_CONFIG0;
      next_r.filter  = '0;
      next_r.filter[0] = RST_FILTER0;
      next_r.pdown   = 1'b0;
      next_r.porFlag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
      r.io      <= RST_IO;
      r.control <= RST_CONTROL;
      r.errEn   <= RST_ERR_EN;
      r.channel[0] <= RST_CHANNEL0;
      r.config_[0] <= RST_CONFIG0;
      r.filter[0]  <= RST_FILTER0;
      r.porFlag <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign regRdata = r.rdata;
endmodule : pmoc_power_ctrl
`default_nettype wire

// File: bench/pmoc_power_monitor.sv
// checker for power mode and output control ports
`timescale 1ns/1ps
`default_nettype none
module pmoc_power_monitor
  import pmoc_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // register port
  input wire logic [5:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWr,
  // controls
  input wire logic [3:0]  outPinData,
  input wire logic [3:0]  outPinEnable,
  input wire logic        bridgeSwitchOn,
  input wire logic        modResetHold,
  input wire logic        standbyActive,
  input wire logic        powerDownActive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire ioWr  = regWr && regAddr == OFS_IO && !powerDownActive;
  wire ctlWr = regWr && regAddr == OFS_CONTROL && !powerDownActive;
  a_out_enable_write: assert property (ioWr |=>
    outPinEnable == $past(regWdata[3:0])) else $error("enable bits not applied");
  a_out_level_write: assert property (ioWr |=>
    outPinData[0] == $past(regWdata[4]) && outPinData[2] == $past(regWdata[6]) &&
    ($past(regWdata[8]) || outPinData[1] == $past(regWdata[5])) &&
    ($past(regWdata[9]) || outPinData[3] == $past(regWdata[7])))
    else $error("level bits not applied");
  a_stby_pin_flag: assert property (ioWr && regWdata[9] |=>
    outPinData[3] == standbyActive) else $error("standby flag pin wrong");
  a_pdown_from_stby: assert property ($rose(powerDownActive) |->
    $past(standbyActive)) else $error("power-down entered outside standby");
  a_pdown_holds: assert property (powerDownActive |=> powerDownActive[*3])
    else $error("power-down left without reset");
  a_pdown_pins_off: assert property (powerDownActive |->
    outPinEnable == 4'h0 && !bridgeSwitchOn) else $error("drive in power-down");
  a_stby_decode: assert property (ctlWr && regWdata[5:2] == 4'b0010 |=>
    standbyActive && !modResetHold) else $error("standby code not decoded");
  a_idle_decode: assert property (ctlWr && regWdata[5:2] == 4'b0100 |=>
    modResetHold && !standbyActive) else $error("idle code not decoded");
  a_pdown_not_stby: assert property (ctlWr && regWdata[5:2] == 4'b0011
    && !standbyActive |=> !powerDownActive && !modResetHold) else $error("bad power-down");
  c_pdown: cover property (powerDownActive);
  c_idle: cover property (modResetHold && !powerDownActive);
  c_stby_write: cover property (standbyActive ##1 ctlWr);
endmodule : pmoc_power_monitor
bind pmoc_power_ctrl pmoc_power_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .outPinData(outPinData),
  .outPinEnable(outPinEnable), .bridgeSwitchOn(bridgeSwitchOn),
  .modResetHold(modResetHold), .standbyActive(standbyActive),
  .powerDownActive(powerDownActive));
`default_nettype wire

// File: bench/pmoc_pin_load.sv
// load model of the general output pins
`timescale 1ns/1ps
`default_nettype none
module pmoc_pin_load (
  // clock
  input  wire logic       clk_sys,
  // pins from the block
  input  wire logic [3:0] outPinData,
  input  wire logic [3:0] outPinEnable,
  // resolved pin level
  output var  logic [3:0] pinLevel
);
  logic [3:0] lastLevel = 4'h0;
  // floating pin shows inverse of last level
  always_comb pinLevel = (outPinEnable & outPinData) | (~outPinEnable & ~lastLevel);
  always_ff @(posedge clk_sys) lastLevel <= pinLevel;
endmodule : pmoc_pin_load
`default_nettype wire

// File: bench/pmoc_power_ctrl_tb_top.sv
// self-checking bench for power mode and output control
`timescale 1ns/1ps
`default_nettype none
module pmoc_power_ctrl_tb_top;
  import pmoc_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic        ioSupplyLow = 1'b0, digLdoLow = 1'b0, anaSupplyLow = 1'b0;
  logic        convReady = 1'b1, convIrq = 1'b0;
  logic [5:0]  regAddr = 6'h00;
  logic [15:0] regWdata = 16'h0000, regRdata, biasSelect, v;
  logic [3:0]  activeChannel = 4'h0, outPinData, outPinEnable, pinLevel;
  logic [2:0]  effectiveGain;
  logic        bridgeSwitchOn, modResetHold, standbyActive, powerDownActive;
  int          num_errors = 0, compares = 0, cyc = 0;
  pmoc_power_ctrl dut (.clk_sys, .rst_n, .ioSupplyLow, .digLdoLow, .anaSupplyLow,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .activeChannel, .convReady,
    .convIrq, .outPinData, .outPinEnable, .biasSelect, .bridgeSwitchOn,
    .effectiveGain, .modResetHold, .standbyActive, .powerDownActive);
  pmoc_pin_load load (.clk_sys, .outPinData, .outPinEnable, .pinLevel);
  always #25 clk_sys = ~clk_sys;
  task automatic conclude;
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge clk_sys) begin
    cyc++;
    convIrq <= 1'($urandom);
    if (cyc == 4000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask : rdc
  function automatic logic [3:0] pinExp(input logic [15:0] c, input logic irq);
    logic [3:0] p;
    p = c[7:4];
    if (c[IO_INT_BIT]) p[1] = irq;
    if (c[IO_SBY_BIT]) p[3] = 1'b0;
    return p;
  endfunction : pinExp
  function automatic logic [2:0] gainExp(input logic [15:0] c);
    return c[CFG_BYP_BIT] ? GAIN_ONE : c[2:0];
  endfunction : gainExp
  task automatic resetVals;
    rdc(OFS_CONTROL, 16'h0040);
    rdc(OFS_IO, 16'h0000);
    rdc(OFS_BIAS, 16'h0000);
    rdc(OFS_ERR_EN, 16'h0001);
    rdc(OFS_CHANNEL0, 16'h8001);
    rdc(OFS_CONFIG0, 16'h0000);
    rdc(OFS_FILTER0, 16'h0030);
    rdc(6'h3F, 16'h0000);
  endtask : resetVals
  initial begin
    v = $urandom(32'hb076_e50e);
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(OFS_STATUS, 16'h0040);
    rdc(OFS_STATUS, 16'h0000);
    resetVals();
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 16'h07FF : (i == 1) ? 16'h0000 : 16'($urandom) & 16'h07FF;
      wr(OFS_IO, v);
      chk(16'(outPinEnable), 16'(v[3:0]));
      chk(16'(outPinData), 16'(pinExp(v, convIrq)));
      chk(16'(pinLevel & v[3:0]), 16'(pinExp(v, convIrq) & v[3:0]));
      rdc(OFS_IO, v);
    end
    v = 16'($urandom);
    wr(OFS_BIAS, v);
    chk(biasSelect, v);
    for (int g = 0; g < 16; g++) begin
      wr(OFS_CONFIG0, 16'(g));
      chk(16'(effectiveGain), 16'(gainExp(16'(g))));
    end
    wr(OFS_CHANNEL0, 16'hC001);
    chk(16'(bridgeSwitchOn), 16'h0001);
    wr(OFS_CHANNEL0, RST_CHANNEL0);
    chk(16'(bridgeSwitchOn), 16'h0000);
    wr(OFS_IO, 16'h00FF);
    wr(OFS_CONTROL, 16'h004C);
    rdc(OFS_CONTROL, 16'h0040);
    wr(OFS_CONTROL, 16'h0050);
    chk(16'(modResetHold), 16'h0001);
    rdc(OFS_IO, 16'h00FF);
    wr(OFS_CONTROL, 16'h004C);
    chk(16'({powerDownActive, modResetHold}), 16'h0000);
    wr(OFS_CONTROL, 16'h0048);
    chk(16'(standbyActive), 16'h0001);
    rdc(OFS_STATUS, 16'h0080);
    wr(OFS_CONTROL, 16'h004C);
    chk(16'({powerDownActive, outPinEnable}), 16'h0010);
    rdc(OFS_CONTROL, 16'h0000);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk(16'(powerDownActive), 16'h0000);
    rdc(OFS_STATUS, 16'h0040);
    resetVals();
    for (int s = 0; s < 3; s++) begin
      wr(OFS_IO, 16'h0055);
      ioSupplyLow  <= (s == 0);
      digLdoLow    <= (s == 1);
      anaSupplyLow <= (s == 2);
      repeat (4) @(posedge clk_sys);
      {ioSupplyLow, digLdoLow, anaSupplyLow} <= 3'b000;
      repeat (6) @(posedge clk_sys);
      rdc(OFS_IO, (s == 2) ? 16'h0055 : 16'h0000);
      rdc(OFS_STATUS, (s == 2) ? 16'h0000 : 16'h0040);
    end
    conclude();
  end
endmodule : pmoc_power_ctrl_tb_top
`default_nettype wire
